//--- ext_bus_pkg.sv
// Shared constants, types and decode helpers for the data-lane block.
// Assumes a 24-bit CPU address with the bank number in the top byte.
package ext_bus_pkg;

    // Bank-zero map
    localparam logic [7:0]  BANK_ZERO    = 8'h00;
    localparam logic [15:0] PERIPH_FIRST = 16'h0000;
    localparam logic [15:0] PERIPH_LAST  = 16'h007f;
    localparam logic [15:0] RAM_FIRST    = 16'h0080;
    localparam logic [15:0] RAM_LAST     = 16'h087f;
    localparam logic [15:0] ROM_FIRST    = 16'h4000;
    localparam logic [15:0] ROM_LAST     = 16'hffff;
    localparam logic [15:0] VEC_FIRST    = 16'hffd2;

    // Lane port register offsets in bank zero
    localparam logic [15:0] OFS_LO_VAL   = 16'h0016;
    localparam logic [15:0] OFS_HI_VAL   = 16'h0017;
    localparam logic [15:0] OFS_LO_DIR   = 16'h0018;
    localparam logic [15:0] OFS_HI_DIR   = 16'h0019;

    // Reset values of the lane port registers
    localparam logic [7:0]  PORT_RESET   = 8'h00;
    localparam logic [7:0]  DIR_RESET    = 8'h00;

    // Strobe-low length of one external cycle, in clocks
    localparam int          STROBE_CYCLES_DEF = 2;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_EXPAND = 2'b01,
        MODE_MICRO  = 2'b10
    } proc_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_INT    = 2'b01,
        ST_ADDR   = 2'b10,
        ST_STROBE = 2'b11
    } bus_state_type;

    typedef enum logic [2:0] {
        REGION_NONE   = 3'b000,
        REGION_PORT   = 3'b001,
        REGION_PERIPH = 3'b010,
        REGION_RAM    = 3'b011,
        REGION_ROM    = 3'b100,
        REGION_EXT    = 3'b101
    } region_type;

    // Region of an address; anything unclaimed goes external off-chip except in single-chip mode, where it is none
    function automatic region_type decode(input logic [23:0]   a,
                                          input proc_mode_type m);
        logic [15:0] o;
        logic        bank0;
        region_type  rg;
        o     = a[15:0];
        bank0 = (a[23:16] == BANK_ZERO);
        if (!bank0) begin
            rg = REGION_NONE;
        end else if ({o[15:1], 1'h0} == OFS_LO_VAL ||
                     {o[15:1], 1'h0} == OFS_LO_DIR) begin
            rg = REGION_PORT;
        end else if (o >= PERIPH_FIRST && o <= PERIPH_LAST) begin
            rg = REGION_PERIPH;
        end else if (o >= RAM_FIRST && o <= RAM_LAST) begin
            rg = REGION_RAM;
        end else if (o >= ROM_FIRST && o <= ROM_LAST &&
                     m != MODE_MICRO) begin
            rg = REGION_ROM;
        end else begin
            rg = REGION_NONE;
        end
        if (rg == REGION_NONE && m != MODE_SINGLE) begin
            rg = REGION_EXT;
        end
        return rg;
    endfunction

    // Vector fetch window at the top of bank zero
    function automatic logic is_vector(input logic [23:0] a);
        return (a[23:16] == BANK_ZERO) && (a[15:0] >= VEC_FIRST);
    endfunction

endpackage

//--- ext_data_lane_and_bank0_decode.sv
// Data-lane steering and bank-zero decode for the expansion bus.
// Assumes pins synchronous to sys_clk and a pad ring resolving enables.
//
// Function
// - 8-bit read: even low half, odd high
// - 8-bit write: even low byte, odd high
// - Internal read: low lane high impedance
// - Internal write: drive bus data onto lanes
// - Muxed area on 8-bit bus: address while strobe high
// - 16-bit read: high lane on odd access
// - 16-bit write: high lane from high half
// - Internal read: high lane high impedance
// - 8-bit bus: high lane is plain port
// - Single-chip: both lanes plain ports
// - 16 MB space, bank in top byte
// - Internal ROM at 4000 to FFFF
// - Vectors at bank-zero FFD2 to FFFF
// - Internal RAM at 80 to 87F
// - Peripheral registers at 0 to 7F
// - Lane port registers at 16 to 19
// - 16-bit read: low lane into low half
// - 16-bit write: low lane from low half
`timescale 1ns/1ps
module ext_data_lane_and_bank0_decode #(
    parameter int STROBE_CYCLES = ext_bus_pkg::STROBE_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Configuration straps
    input  wire logic        cfg_bus16,
    input  wire logic [1:0]  cfg_mode,
    input  wire logic        mux_enable,
    input  wire logic [7:0]  mux_bank,
    // CPU request
    input  wire logic        cpu_valid,
    output logic             cpu_ready,
    input  wire logic        cpu_write,
    input  wire logic        cpu_word,
    input  wire logic [23:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    // Internal memory read data
    input  wire logic [15:0] int_rdata,
    // Read answer
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic [15:0]      rsp_data,
    // Region selects
    output logic             sel_periph,
    output logic             sel_ram,
    output logic             sel_rom,
    output logic             sel_vector,
    // External bus control
    output logic [23:0]      ext_addr,
    output logic             ext_rd_n,
    output logic             ext_wr_n,
    // Low data lane pins
    input  wire logic [7:0]  lo_in,
    output logic [7:0]       lo_out,
    output logic [7:0]       lo_oe_n,
    // High data lane pins
    input  wire logic [7:0]  hi_in,
    output logic [7:0]       hi_out,
    output logic [7:0]       hi_oe_n
);
    localparam int CW = $clog2(STROBE_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(STROBE_CYCLES - 1);
    typedef struct packed {
        ext_bus_pkg::bus_state_type fsm;
        ext_bus_pkg::proc_mode_type mode;
        ext_bus_pkg::region_type    region;
        logic                       bus16, cfg_done;
        logic [7:0]                 lo_val, hi_val, lo_dir, hi_dir;
        logic [23:0]                addr;
        logic [15:0]                wdata;
        logic                       write, word, second, mux;
        logic [CW-1:0]              cnt;
        logic [15:0]                rdata;
        logic                       push;
        logic [3:0]                 sel;
        logic [7:0]                 lo_out, lo_oe_n, hi_out, hi_oe_n;
        logic                       rd_n, wr_n;
    } lane_state_type;
    lane_state_type          r;
    lane_state_type          n;
    ext_bus_pkg::region_type rg;
    logic                    accept;
    logic                    buf_in_ready;
    logic                    drive;
    logic [15:0]             port_base;
    // Port pin readback: latch on outputs, pin on inputs
    function automatic logic [7:0] port_read(input logic [7:0] val,
                                             input logic [7:0] dir,
                                             input logic [7:0] pin);
        return (val & dir) | (pin & ~dir);
    endfunction
    // Byte on the low lane for a write
    function automatic logic [7:0] lane_byte(input logic        wide,
                                             input logic        odd,
                                             input logic [15:0] d);
        return (!wide && odd) ? d[15:8] : d[7:0];
    endfunction
    // Handshake and selects
    assign accept     = cpu_valid && cpu_ready;
    assign cpu_ready  = r.cfg_done && (r.fsm == ext_bus_pkg::ST_IDLE) &&
                        buf_in_ready && !r.push;
    assign rg         = ext_bus_pkg::decode(cpu_addr, r.mode);
    assign port_base  = {r.addr[15:1], 1'h0};
    assign {sel_vector, sel_rom, sel_ram, sel_periph} = r.sel;
    assign ext_addr   = r.addr;
    assign ext_rd_n   = r.rd_n;
    assign ext_wr_n   = r.wr_n;
    assign {lo_out, lo_oe_n} = {r.lo_out, r.lo_oe_n};
    assign {hi_out, hi_oe_n} = {r.hi_out, r.hi_oe_n};
    // Bus sequencer, register file and pin drive
    always_comb begin
        n      = r;
        n.push = 1'h0;
        if (!r.cfg_done) begin
            n.bus16    = cfg_bus16;
            n.mode     = ext_bus_pkg::proc_mode_type'(cfg_mode);
            n.cfg_done = 1'h1;
        end
        case (r.fsm)
            ext_bus_pkg::ST_IDLE: begin
                n.sel = 4'h0;
                if (accept) begin
                    n.addr   = cpu_addr;
                    n.wdata  = cpu_wdata;
                    n.write  = cpu_write;
                    n.word   = cpu_word && !cpu_addr[0];
                    n.second = 1'h0;
                    n.rdata  = 16'h0000;
                    n.region = rg;
                    n.mux    = mux_enable && !r.bus16 &&
                               (cpu_addr[23:16] == mux_bank);
                    n.sel[0] = (rg == ext_bus_pkg::REGION_PERIPH) ||
                               (rg == ext_bus_pkg::REGION_PORT);
                    n.sel[1] = (rg == ext_bus_pkg::REGION_RAM);
                    n.sel[2] = (rg == ext_bus_pkg::REGION_ROM);
                    n.sel[3] = ext_bus_pkg::is_vector(cpu_addr);
                    if (rg == ext_bus_pkg::REGION_EXT) begin
                        n.fsm = ext_bus_pkg::ST_ADDR;
                    end else begin
                        n.fsm = ext_bus_pkg::ST_INT;
                    end
                end
            end
            ext_bus_pkg::ST_INT: begin
                // Lane port registers, pairs aligned on even offsets
                if (r.region == ext_bus_pkg::REGION_PORT && r.write) begin
                    if (port_base == ext_bus_pkg::OFS_LO_VAL) begin
                        if (!r.addr[0]) n.lo_val = r.wdata[7:0];
                        if (r.addr[0] || r.word) n.hi_val = r.wdata[15:8];
                    end else begin
                        if (!r.addr[0]) n.lo_dir = r.wdata[7:0];
                        if (r.addr[0] || r.word) n.hi_dir = r.wdata[15:8];
                    end
                end
                if (!r.write) begin
                    if (r.region == ext_bus_pkg::REGION_PORT) begin
                        if (port_base == ext_bus_pkg::OFS_LO_VAL) begin
                            n.rdata = {port_read(r.hi_val, r.hi_dir, hi_in),
                                       port_read(r.lo_val, r.lo_dir, lo_in)};
                        end else begin
                            n.rdata = {r.hi_dir, r.lo_dir};
                        end
                    end else if (r.region == ext_bus_pkg::REGION_NONE) begin
                        n.rdata = 16'h0000;
                    end else begin
                        n.rdata = int_rdata;
                    end
                    n.push = 1'h1;
                end
                n.sel = 4'h0;
                n.fsm = ext_bus_pkg::ST_IDLE;
            end
            ext_bus_pkg::ST_ADDR: begin
                n.cnt = '0;
                n.fsm = ext_bus_pkg::ST_STROBE;
            end
            ext_bus_pkg::ST_STROBE: begin
                if (r.cnt == CNT_LAST) begin
                    // Capture read lanes on the last strobe-low clock
                    if (!r.write && r.bus16) begin
                        if (!r.addr[0]) n.rdata[7:0] = lo_in;
                        if (r.addr[0] || r.word) begin
                            n.rdata[15:8] = hi_in;
                        end
                    end else if (!r.write) begin
                        if (r.addr[0]) n.rdata[15:8] = lo_in;
                        else n.rdata[7:0] = lo_in;
                    end
                    if (!r.bus16 && r.word && !r.second) begin
                        n.second = 1'h1;
                        n.addr   = {r.addr[23:1], 1'h1};
                        n.fsm    = ext_bus_pkg::ST_ADDR;
                    end else begin
                        n.push = !r.write;
                        n.sel  = 4'h0;
                        n.fsm  = ext_bus_pkg::ST_IDLE;
                    end
                end else begin
                    n.cnt = r.cnt + 1'h1;
                end
            end
            default: n.fsm = ext_bus_pkg::ST_IDLE;
        endcase
        // Pin drive for the coming cycle
        drive = n.write && (n.fsm != ext_bus_pkg::ST_IDLE);
        if (n.mode == ext_bus_pkg::MODE_SINGLE) begin
            n.lo_out  = n.lo_val;
            n.lo_oe_n = ~n.lo_dir;
        end else if (n.fsm == ext_bus_pkg::ST_ADDR && n.mux) begin
            n.lo_out  = n.addr[7:0];
            n.lo_oe_n = 8'h00;
        end else if (drive) begin
            n.lo_out  = lane_byte(n.bus16 || n.fsm == ext_bus_pkg::ST_INT,
                                  n.addr[0], n.wdata);
            n.lo_oe_n = 8'h00;
        end else begin
            n.lo_out  = 8'h00;
            n.lo_oe_n = 8'hff;
        end
        if (n.mode == ext_bus_pkg::MODE_SINGLE || !n.bus16) begin
            n.hi_out  = n.hi_val;
            n.hi_oe_n = ~n.hi_dir;
        end else if (drive) begin
            n.hi_out  = n.wdata[15:8];
            n.hi_oe_n = 8'h00;
        end else begin
            n.hi_out  = 8'h00;
            n.hi_oe_n = 8'hff;
        end
        n.rd_n = !(n.fsm == ext_bus_pkg::ST_STROBE && !n.write);
        n.wr_n = !(n.fsm == ext_bus_pkg::ST_STROBE && n.write);
    end
    // State register; lanes float and strobes idle at reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r         <= '0;
            r.lo_val  <= ext_bus_pkg::PORT_RESET;
            r.hi_val  <= ext_bus_pkg::PORT_RESET;
            r.lo_dir  <= ext_bus_pkg::DIR_RESET;
            r.hi_dir  <= ext_bus_pkg::DIR_RESET;
            r.lo_oe_n <= 8'hff;
            r.hi_oe_n <= 8'hff;
            r.rd_n    <= 1'h1;
            r.wr_n    <= 1'h1;
        end else begin
            r <= n;
        end
    end
    // Read answers wait here while the receiver stalls
    two_entry_buffer #(
        .WIDTH (16),
        .DEPTH (2)
    ) u_rsp_buf (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .in_valid  (r.push),
        .in_ready  (buf_in_ready),
        .in_data   (r.rdata),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  (rsp_data)
    );
    // Checks on lane behaviour, external cycle issue and ROM select
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_byte_rd_steer: assert property (
        (r.fsm == ext_bus_pkg::ST_STROBE && !r.write && !r.bus16 &&
         r.cnt == CNT_LAST && !(r.word && !r.second)) |=>
        (r.push && (r.addr[0] ? r.rdata[15:8] == $past(lo_in)
                              : r.rdata[7:0] == $past(lo_in))))
        else $error("byte read lane steering wrong");
    a_byte_wr_steer: assert property (
        (r.fsm == ext_bus_pkg::ST_STROBE && r.write && !r.bus16) |->
        (lo_oe_n == 8'h00 && !ext_wr_n &&
         lo_out == (r.addr[0] ? r.wdata[15:8] : r.wdata[7:0])))
        else $error("byte write lane steering wrong");
    a_int_rd_lowz: assert property (
        (r.fsm == ext_bus_pkg::ST_INT && !r.write &&
         r.mode != ext_bus_pkg::MODE_SINGLE) |-> lo_oe_n == 8'hff)
        else $error("low lane driven on internal read");
    a_int_wr_drive: assert property (
        (r.fsm == ext_bus_pkg::ST_INT && r.write &&
         r.mode != ext_bus_pkg::MODE_SINGLE) |->
        (lo_oe_n == 8'h00 && lo_out == r.wdata[7:0]))
        else $error("internal write not on low lane");
    a_mux_addr_out: assert property (
        (r.fsm == ext_bus_pkg::ST_ADDR && r.mux) |->
        (lo_out == r.addr[7:0] && lo_oe_n == 8'h00 && ext_rd_n && ext_wr_n))
        else $error("muxed low address missing");
    a_wide_rd_high: assert property (
        (r.fsm == ext_bus_pkg::ST_STROBE && !r.write && r.bus16 &&
         r.cnt == CNT_LAST && (r.addr[0] || r.word)) |=>
        (r.rdata[15:8] == $past(hi_in) && r.push))
        else $error("high lane not captured");
    a_wide_wr_high: assert property (
        (r.fsm == ext_bus_pkg::ST_STROBE && r.write && r.bus16) |->
        (hi_oe_n == 8'h00 && hi_out == r.wdata[15:8]))
        else $error("high lane write wrong");
    a_int_rd_highz: assert property (
        (r.fsm == ext_bus_pkg::ST_INT && !r.write && r.bus16 &&
         r.mode != ext_bus_pkg::MODE_SINGLE) |-> hi_oe_n == 8'hff)
        else $error("high lane driven on internal read");
    a_high_gpio8: assert property (
        (r.cfg_done && !r.bus16) |->
        (hi_out == r.hi_val && hi_oe_n == ~r.hi_dir))
        else $error("high lane not a port on 8-bit bus");
    a_single_gpio: assert property (
        (r.cfg_done && r.mode == ext_bus_pkg::MODE_SINGLE) |->
        (lo_oe_n == ~r.lo_dir && lo_out == r.lo_val && ext_rd_n &&
         ext_wr_n))
        else $error("bus activity in single-chip mode");
    a_ext_issue: assert property (
        (accept && rg == ext_bus_pkg::REGION_EXT) |=>
        (r.fsm == ext_bus_pkg::ST_ADDR) ##1 (!ext_rd_n || !ext_wr_n))
        else $error("external cycle not issued");
    a_rom_select: assert property (
        (accept && cpu_addr[23:16] == ext_bus_pkg::BANK_ZERO &&
         cpu_addr[15:0] >= ext_bus_pkg::ROM_FIRST &&
         r.mode == ext_bus_pkg::MODE_EXPAND) |=> sel_rom)
        else $error("internal ROM not selected");
    c_wide_read:  cover property (r.fsm == ext_bus_pkg::ST_STROBE &&
                                  !r.write && r.bus16);
    c_byte_word:  cover property (r.second &&
                                  r.fsm == ext_bus_pkg::ST_STROBE);
    c_mux_cycle:  cover property (r.fsm == ext_bus_pkg::ST_ADDR && r.mux);
    c_rsp_stall:  cover property (rsp_valid && !rsp_ready && !buf_in_ready);
endmodule

//--- ext_data_lane_and_bank0_decode_test.sv
// Self-checking bench for lane steering and bank-zero decode.
// Assumes ext_mem_model on the lanes and a 50 MHz clock.
`timescale 1ns/1ps
module ext_data_lane_and_bank0_decode_test;
    logic        sys_clk, nrst, cfg_bus16, cpu_valid, cpu_write, cpu_word;
    logic [1:0]  cfg_mode;
    logic [23:0] cpu_addr;
    logic [15:0] cpu_wdata, rsp_data, q, oes;
    logic        cpu_ready, rsp_valid, ext_rd_n, ext_wr_n, mux_en, rsp_rdy;
    logic        sel_periph, sel_ram, sel_rom, sel_vector;
    logic [23:0] ext_addr;
    logic [7:0]  lo_in, lo_out, lo_oe_n, hi_in, hi_out, hi_oe_n;
    logic [7:0]  last_lo, last_hi;
    logic [3:0]  sels;
    int          fails = 0;
    int          compares = 0;
    ext_data_lane_and_bank0_decode dut (.sys_clk(sys_clk), .nrst(nrst),
        .cfg_bus16(cfg_bus16), .cfg_mode(cfg_mode), .mux_enable(mux_en),
        .mux_bank(8'h02), .cpu_valid(cpu_valid), .cpu_ready(cpu_ready),
        .cpu_write(cpu_write), .cpu_word(cpu_word), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .int_rdata(16'hc3e1),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_rdy), .rsp_data(rsp_data),
        .sel_periph(sel_periph), .sel_ram(sel_ram), .sel_rom(sel_rom),
        .sel_vector(sel_vector), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
        .ext_wr_n(ext_wr_n), .lo_in(lo_in), .lo_out(lo_out),
        .lo_oe_n(lo_oe_n), .hi_in(hi_in), .hi_out(hi_out), .hi_oe_n(hi_oe_n));
    ext_mem_model mem (.sys_clk(sys_clk), .cfg_bus16(cfg_bus16),
        .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
        .lo_out(lo_out), .hi_out(hi_out), .lo_in(lo_in), .hi_in(hi_in),
        .last_lo(last_lo), .last_hi(last_hi));
    // Clock
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic rst(input logic b16, input logic [1:0] m);
        nrst = 1'h0;
        cfg_bus16 = b16;
        cfg_mode = m;
        repeat (4) @(posedge sys_clk);
        #1 nrst = 1'h1;
    endtask
    // One CPU access; read answer lands in q
    task automatic acc(input logic w, input logic wd, input logic [23:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        #1 cpu_valid = 1'h1;
        cpu_write = w;
        cpu_word = wd;
        cpu_addr = a;
        cpu_wdata = d;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cpu_ready !== 1'h1 && n < 50);
        @(posedge sys_clk);
        #1 sels = {sel_periph, sel_ram, sel_rom, sel_vector};
        oes = {lo_oe_n, hi_oe_n};
        cpu_valid = 1'h0;
        while (!w && rsp_valid !== 1'h1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        q = rsp_data;
        if (n >= 50) fails++;
    endtask
    task automatic t_int;
        logic [23:0] a[4] = '{24'h000100, 24'h004000, 24'h000020, 24'h00fffe};
        logic [3:0]  s[4] = '{4'h4, 4'h2, 4'h8, 4'h3};
        rst(1'h1, ext_bus_pkg::MODE_EXPAND);
        for (int i = 0; i < 4; i++) begin
            acc(1'h0, 1'h1, a[i], 16'h0000);
            chk(16'(sels), 16'(s[i]));
            chk(oes, 16'hffff);
            chk(q, 16'hc3e1);
        end
        $display("internal decode test done");
    endtask
    task automatic t_ext16;
        rst(1'h1, ext_bus_pkg::MODE_MICRO);
        acc(1'h1, 1'h1, 24'h010004, 16'h1234);
        acc(1'h0, 1'h1, 24'h010004, 16'h0000);
        chk({last_hi, last_lo}, 16'h1234);
        chk(q, 16'h5f5e);
        chk({12'h000, sels}, 16'h0000);
        acc(1'h0, 1'h0, 24'h004001, 16'h0000);
        chk({q[15:8], 8'h00}, 16'h5b00);
        $display("wide external test done");
    endtask
    task automatic t_ext8;
        rst(1'h0, ext_bus_pkg::MODE_EXPAND);
        acc(1'h1, 1'h0, 24'h010003, 16'h3c00);
        acc(1'h0, 1'h0, 24'h010007, 16'h0000);
        chk({last_lo, 8'h00}, 16'h3c00);
        chk({q[15:8], 8'h00}, 16'h5d00);
        acc(1'h0, 1'h1, 24'h010006, 16'h0000);
        chk(q, 16'h5d5c);
        acc(1'h1, 1'h0, 24'h000019, 16'hff00);
        acc(1'h1, 1'h0, 24'h000017, 16'h96c5);
        chk({lo_out, lo_oe_n}, 16'hc500);
        acc(1'h0, 1'h0, 24'h000017, 16'h0000);
        chk({q[15:8], 8'h00}, 16'h9600);
        chk({hi_out, hi_oe_n}, 16'h9600);
        $display("narrow external test done");
    endtask
    task automatic t_mux;
        rst(1'h0, ext_bus_pkg::MODE_EXPAND);
        mux_en = 1'h1;
        acc(1'h1, 1'h0, 24'h020044, 16'h00a7);
        chk({lo_out, lo_oe_n}, 16'h4400);
        chk(ext_addr[15:0], 16'h0044);
        acc(1'h0, 1'h0, 24'h020045, 16'h0000);
        chk({last_lo, 8'h00}, 16'ha700);
        chk({q[15:8], 8'h00}, 16'h1f00);
        mux_en = 1'h0;
        $display("muxed lane test done");
    endtask
    task automatic t_single;
        rst(1'h1, ext_bus_pkg::MODE_SINGLE);
        acc(1'h1, 1'h1, 24'h000018, 16'hffff);
        acc(1'h1, 1'h1, 24'h000016, 16'h96a5);
        acc(1'h0, 1'h1, 24'h000016, 16'h0000);
        chk(q, 16'h96a5);
        chk({lo_out, lo_oe_n}, 16'ha500);
        chk({hi_out, hi_oe_n}, 16'h9600);
        @(posedge sys_clk);
        #1 rsp_rdy = 1'h0;
        acc(1'h0, 1'h1, 24'h000016, 16'h0000);
        acc(1'h0, 1'h1, 24'h000018, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1 chk(16'(cpu_ready), 16'h0000);
        chk(rsp_data, 16'h96a5);
        rsp_rdy = 1'h1;
        @(posedge sys_clk);
        #1 chk(rsp_data, 16'hffff);
        $display("single-chip port test done");
    endtask
    task automatic wrap_up;
        $display("%0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        cpu_valid = 1'h0;
        cpu_write = 1'h0;
        cpu_word = 1'h0;
        cpu_addr = 24'h000000;
        cpu_wdata = 16'h0000;
        mux_en = 1'h0;
        rsp_rdy = 1'h1;
        t_int;
        t_ext16;
        t_ext8;
        t_mux;
        t_single;
        wrap_up;
    end
    // Watchdog well beyond the hundred or so cycles needed
    initial begin
        #100000;
        fails++;
        wrap_up;
    end
endmodule

//--- ext_mem_model.sv
// External memory on the expansion bus, byte value = address xor 5a.
// Assumes the block's registered strobes and one shared clock.
`timescale 1ns/1ps
module ext_mem_model (
    // Clock and lane width
    input  wire logic        sys_clk,
    input  wire logic        cfg_bus16,
    // Bus control from the block
    input  wire logic [23:0] ext_addr,
    input  wire logic        ext_rd_n,
    input  wire logic        ext_wr_n,
    // Data lanes
    input  wire logic [7:0]  lo_out,
    input  wire logic [7:0]  hi_out,
    output logic [7:0]       lo_in,
    output logic [7:0]       hi_in,
    // Last written lane values
    output logic [7:0]       last_lo,
    output logic [7:0]       last_hi
);
    logic [7:0] noise = 8'h69;
    logic [7:0] ev;
    // Changing pattern so a released lane never looks valid
    always @(posedge sys_clk) begin
        noise <= ~noise;
        if (!ext_wr_n) begin
            last_lo <= lo_out;
            last_hi <= hi_out;
        end
    end
    // Even byte on low lane, odd byte on high lane for a wide bus
    assign ev = cfg_bus16 ? {ext_addr[7:1], 1'h0} : ext_addr[7:0];
    assign lo_in = !ext_rd_n ? ev ^ 8'h5a : noise;
    assign hi_in = !ext_rd_n ? {ev[7:1], 1'h1} ^ 8'h5a : ~noise;
endmodule

//--- two_entry_buffer.sv
// Small valid/ready buffer for read answers.
// Assumes one clock; the drain side may stall freely.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } buf_state_type;

    buf_state_type r;
    buf_state_type n;
    logic          do_push;
    logic          do_pop;

    // Pointer step with wrap at the depth
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return AW'(p + 1'h1);
    endfunction

    // Honest full and empty from the entry count
    assign in_ready  = (r.cnt != FULL_COUNT);
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rp];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    // Next state of storage and pointers
    always_comb begin
        n = r;
        if (do_push) begin
            n.mem[r.wp] = in_data;
            n.wp        = step(r.wp);
        end
        if (do_pop) begin
            n.rp = step(r.rp);
        end
        if (do_push && !do_pop) begin
            n.cnt = r.cnt + 1'h1;
        end else if (do_pop && !do_push) begin
            n.cnt = r.cnt - 1'h1;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule
